// >>> gms_pkg.sv
// Package with constants and carrier types for the genset mode sequencer.
package gms_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned TMR_W            = 32;
  localparam int unsigned TRY_W            = 4;
  localparam int unsigned SYNC_STAGES      = 3;
  localparam int unsigned IDLE_TIME_MS     = 10000;
  localparam int unsigned IDLE_TICKS       = IDLE_TIME_MS * 1000 * CLK_MHZ;
  localparam logic [TRY_W-1:0] TRY_ZERO    = 4'h0;
  localparam logic [TRY_W-1:0] TRY_ONE     = 4'h1;
  localparam logic [TMR_W-1:0] TMR_ZERO    = 32'h0000_0000;
  localparam logic [TMR_W-1:0] TMR_ONE     = 32'h0000_0001;

  // ---------------------------------------------------------------------------
  // Modes and sequence states
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    GMS_MODE_STOP,
    GMS_MODE_MANUAL,
    GMS_MODE_AUTO,
    GMS_MODE_TEST
  } gms_mode_type;

  typedef enum logic [2:0]
  {
    GMS_SEQ_IDLE,
    GMS_SEQ_CRANK,
    GMS_SEQ_REST,
    GMS_SEQ_SAFETY,
    GMS_SEQ_RUN,
    GMS_SEQ_FAILED
  } gms_seq_type;

  // Fascia buttons, one bit each.
  typedef struct packed
  {
    logic stop_reset;
    logic manual;
    logic auto_mode;
    logic test;
    logic start;
    logic to_gen;
    logic open_gen;
  } gms_buttons_type;

  // Engine-at-rest sensor summary, each bit high when the quantity is zero/low.
  typedef struct packed
  {
    logic ecu_speed_zero;
    logic gen_volt_zero;
    logic gen_freq_zero;
    logic charge_volt_zero;
    logic oil_press_low;
  } gms_rest_type;

  // Firing indications from the speed sources and the oil pressure rise.
  typedef struct packed
  {
    logic alt_freq_fired;
    logic mag_pickup_fired;
    logic ecu_speed_fired;
    logic oil_press_rising;
  } gms_fire_type;

  // Static configuration.
  typedef struct packed
  {
    logic             use_mag_pickup;
    logic             use_ecu_speed;
    logic             use_oil_cutout;
    logic             can_engine;
    logic             manual_breaker;
    logic             mains_dropout;
    logic             power_save_en;
    logic [TRY_W-1:0] crank_try_limit;
    logic [TMR_W-1:0] crank_ticks;
    logic [TMR_W-1:0] rest_ticks;
    logic [TMR_W-1:0] safety_ticks;
    logic [TMR_W-1:0] stop_ticks;
  } gms_cfg_type;

endpackage : gms_pkg

// >>> gms_sync.sv
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/100ps
module gms_sync
#(
  parameter int unsigned WIDTH = 1
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  import gms_pkg::*;

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] out_ff;
  logic [WIDTH-1:0] nxt_out;

  // ---------------------------------------------------------------------------
  // Stages
  // ---------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      // A change counts once the second and third stage agree.
      assign nxt_out[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] : out_ff[gi];
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1_ff  <= '0;
      s2_ff  <= '0;
      s3_ff  <= '0;
      out_ff <= '0;
    end
    else
    begin
      s1_ff  <= din;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign dout = out_ff;

endmodule : gms_sync

// >>> gms_sequencer.sv
// Mode and engine-start sequencer for a generator set controller.
//
// Contract
// - Panel lock blocks all mode changes.
// - Stop mode opens generator switch before stopping.
// - Engine not at rest at timeout raises alarm.
// - At rest needs all five zero/low conditions.
// - Entering stop resets latched alarms already cleared.
// - Stop mode never starts; start signals ignored.
// - Stop mode dropout follows mains availability.
// - Idle stop mode enters power save; buttons wake.
// - Start in stop mode primes ECU only.
// - Stopped in stop mode permits config edits.
// - Manual mode starts only on start press.
// - Sequence start energises fuel and cranks.
// - Failed crank rests then retries.
// - Exhausted attempts end sequence, raise alarm.
// - Starter released on firing, selectable sources.
// - Oil pressure optional cut-out only.
// - Safety-on delay masks faults after disengage.
// - Load transfer held until generator available.
// - Manual mode loads on permitted requests.
// - CAN engine receives start command.
`timescale 1ns/100ps
module gms_sequencer
#(
  parameter int unsigned IDLE_LIMIT = gms_pkg::IDLE_TICKS
)
(
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire gms_pkg::gms_buttons_type buttons,
  input  wire logic                     panel_lock,
  input  wire logic                     comms_active,
  input  wire gms_pkg::gms_rest_type    rest_in,
  input  wire gms_pkg::gms_fire_type    fire_in,
  input  wire logic                     gen_available,
  input  wire logic                     mains_ok,
  input  wire logic                     aux_load_req,
  input  wire logic                     remote_load_req,
  input  wire logic                     load_inhibit,
  input  wire logic                     alarm_cond_clear,
  input  wire gms_pkg::gms_cfg_type     cfg,
  output gms_pkg::gms_mode_type         mode,
  output logic                          fuel_relay,
  output logic                          starter,
  output logic                          can_start_cmd,
  output logic                          engine_computer_prime,
  output logic                          gen_load_switch,
  output logic                          mains_load_switch,
  output logic                          safety_mask,
  output logic                          stop_timeout_alarm,
  output logic                          start_exhausted_alarm,
  output logic                          latched_alarm_reset,
  output logic                          power_save,
  output logic                          config_allowed,
  output logic                          engine_at_rest
);
  import gms_pkg::*;

  // ---------------------------------------------------------------------------
  // Synchronised pin inputs
  // ---------------------------------------------------------------------------
  localparam int unsigned NSYNC = $bits(gms_buttons_type) + 1
                                + $bits(gms_rest_type) + $bits(gms_fire_type)
                                + 5;

  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] syn_in;
  gms_buttons_type  btn;
  gms_rest_type     rst_s;
  gms_fire_type     fire_s;
  logic             lock_s;
  logic             avail_s;
  logic             mains_s;
  logic             aux_s;
  logic             inhibit_s;
  logic             commq_s;

  assign raw_in = {buttons, panel_lock, rest_in, fire_in, gen_available,
                   mains_ok, aux_load_req, load_inhibit, comms_active};

  gms_sync #(.WIDTH(NSYNC)) u_sync
  (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (raw_in),
    .dout  (syn_in)
  );

  assign {btn, lock_s, rst_s, fire_s, avail_s, mains_s, aux_s, inhibit_s,
          commq_s} = syn_in;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  gms_mode_type    mode_ff;
  gms_seq_type     seq_ff;
  gms_buttons_type btn_prev_ff;
  logic [TMR_W-1:0] tmr_ff;
  logic [TMR_W-1:0] stop_tmr_ff;
  logic [TMR_W-1:0] idle_ff;
  logic [TRY_W-1:0] tries_ff;
  logic fuel_ff;
  logic starter_ff;
  logic can_ff;
  logic prime_ff;
  logic gen_sw_ff;
  logic mains_sw_ff;
  logic mask_ff;
  logic fts_ff;
  logic fst_ff;
  logic alm_rst_ff;
  logic psave_ff;
  logic cfg_ok_ff;
  logic rest_ff;
  logic stopping_ff;
  logic fst_late_ff;

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  gms_buttons_type press;
  logic any_press;
  logic at_rest;
  logic fired;
  logic in_stop;
  logic in_manual;
  logic mode_req;
  gms_mode_type req_mode;
  logic enter_stop;
  logic start_req;
  logic tmr_done;
  logic tries_left;
  logic load_req;
  logic want_gen_load;
  logic gen_running;
  logic idle_done;

  assign press     = btn & ~btn_prev_ff;
  assign any_press = |press;

  assign at_rest = rst_s.ecu_speed_zero & rst_s.gen_volt_zero
                 & rst_s.gen_freq_zero & rst_s.charge_volt_zero
                 & rst_s.oil_press_low;

  assign fired = fire_s.alt_freq_fired
               | (cfg.use_mag_pickup & fire_s.mag_pickup_fired)
               | (cfg.use_ecu_speed  & fire_s.ecu_speed_fired)
               | (cfg.use_oil_cutout & fire_s.oil_press_rising);

  assign in_stop   = (mode_ff == GMS_MODE_STOP);
  assign in_manual = (mode_ff == GMS_MODE_MANUAL);

  assign mode_req = !lock_s & (press.stop_reset | press.manual
                  | press.auto_mode | press.test);
  assign req_mode = press.stop_reset ? GMS_MODE_STOP
                  : press.manual     ? GMS_MODE_MANUAL
                  : press.auto_mode  ? GMS_MODE_AUTO
                  :                    GMS_MODE_TEST;
  assign enter_stop = mode_req & press.stop_reset & !in_stop;

  // Start press counts only in manual or test mode.
  assign start_req = press.start & !in_stop
                   & (in_manual | (mode_ff == GMS_MODE_TEST))
                   & (seq_ff == GMS_SEQ_IDLE | seq_ff == GMS_SEQ_FAILED);

  assign tmr_done   = (tmr_ff == TMR_ZERO);
  assign tries_left = (tries_ff < cfg.crank_try_limit);
  assign gen_running = (seq_ff == GMS_SEQ_SAFETY) | (seq_ff == GMS_SEQ_RUN);

  assign load_req = press.to_gen | aux_s
                  | (!cfg.manual_breaker & remote_load_req);
  assign want_gen_load = gen_running & avail_s & !inhibit_s
                       & !in_stop;
  assign idle_done = (idle_ff >= TMR_W'(IDLE_LIMIT));

  // ---------------------------------------------------------------------------
  // Mode register
  // ---------------------------------------------------------------------------
  gms_mode_type nxt_mode;
  assign nxt_mode = mode_req ? req_mode : mode_ff;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mode_ff     <= GMS_MODE_STOP;
      btn_prev_ff <= '0;
    end
    else
    begin
      mode_ff     <= nxt_mode;
      btn_prev_ff <= btn;
    end
  end

  // ---------------------------------------------------------------------------
  // Start sequence
  // ---------------------------------------------------------------------------
  gms_seq_type      nxt_seq;
  logic [TMR_W-1:0] nxt_tmr;
  logic [TRY_W-1:0] nxt_tries;
  logic             nxt_fst;

  always_comb
  begin
    nxt_seq   = seq_ff;
    nxt_tmr   = tmr_done ? TMR_ZERO : tmr_ff - TMR_ONE;
    nxt_tries = tries_ff;
    nxt_fst   = fst_ff;
    if (mode_req & press.stop_reset)
    begin
      nxt_seq = GMS_SEQ_IDLE;
      nxt_tmr = TMR_ZERO;
    end
    else
    begin
      case (seq_ff)
        GMS_SEQ_IDLE, GMS_SEQ_FAILED:
        begin
          if (start_req)
          begin
            nxt_seq   = GMS_SEQ_CRANK;
            nxt_tmr   = cfg.crank_ticks;
            nxt_tries = TRY_ZERO;
            nxt_fst   = 1'b0;
          end
        end
        GMS_SEQ_CRANK:
        begin
          if (fired)
          begin
            nxt_seq   = GMS_SEQ_SAFETY;
            nxt_tmr   = cfg.safety_ticks;
            nxt_tries = tries_ff + TRY_ONE;
          end
          else if (tmr_done)
          begin
            nxt_tries = tries_ff + TRY_ONE;
            if ((tries_ff + TRY_ONE) >= cfg.crank_try_limit)
            begin
              nxt_seq = GMS_SEQ_FAILED;
              nxt_fst = 1'b1;
            end
            else
            begin
              nxt_seq = GMS_SEQ_REST;
              nxt_tmr = cfg.rest_ticks;
            end
          end
        end
        GMS_SEQ_REST:
        begin
          if (tmr_done)
          begin
            nxt_seq = tries_left ? GMS_SEQ_CRANK : GMS_SEQ_FAILED;
            nxt_tmr = cfg.crank_ticks;
          end
        end
        GMS_SEQ_SAFETY:
        begin
          if (tmr_done)
          begin
            nxt_seq = GMS_SEQ_RUN;
          end
        end
        default:
        begin
          nxt_seq = seq_ff;
        end
      endcase
    end
    if (enter_stop)
    begin
      nxt_fst = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      seq_ff   <= GMS_SEQ_IDLE;
      tmr_ff   <= TMR_ZERO;
      tries_ff <= TRY_ZERO;
      fst_ff   <= 1'b0;
    end
    else
    begin
      seq_ff   <= nxt_seq;
      tmr_ff   <= nxt_tmr;
      tries_ff <= nxt_tries;
      fst_ff   <= nxt_fst;
    end
  end

  // ---------------------------------------------------------------------------
  // Stop handling and stop_timeout_alarm
  // ---------------------------------------------------------------------------
  logic             nxt_stopping;
  logic [TMR_W-1:0] nxt_stop_tmr;
  logic             nxt_fts;
  logic             stop_expired;

  assign stop_expired = stopping_ff & (stop_tmr_ff == TMR_ZERO);
  assign nxt_stopping = enter_stop ? 1'b1
                      : (at_rest | !in_stop) ? 1'b0 : stopping_ff;
  assign nxt_stop_tmr = enter_stop ? cfg.stop_ticks
                      : (stop_tmr_ff == TMR_ZERO) ? TMR_ZERO
                      : stop_tmr_ff - TMR_ONE;
  // The expiry set wins over the alarm reset on the same edge.
  assign nxt_fts = (stop_expired & !at_rest) ? 1'b1
                 : (enter_stop & alarm_cond_clear) ? 1'b0 : fts_ff;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stopping_ff <= 1'b0;
      stop_tmr_ff <= TMR_ZERO;
      fts_ff      <= 1'b0;
      alm_rst_ff  <= 1'b0;
    end
    else
    begin
      stopping_ff <= nxt_stopping;
      stop_tmr_ff <= nxt_stop_tmr;
      fts_ff      <= nxt_fts;
      alm_rst_ff  <= enter_stop & alarm_cond_clear;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs: fuel, starter, ECU, load switches, power save
  // ---------------------------------------------------------------------------
  logic nxt_fuel;
  logic nxt_starter;
  logic nxt_prime;
  logic nxt_gen_sw;
  logic nxt_mains_sw;
  logic nxt_psave;
  logic [TMR_W-1:0] nxt_idle;

  assign nxt_fuel    = (nxt_seq == GMS_SEQ_CRANK) | (nxt_seq == GMS_SEQ_REST)
                     | (nxt_seq == GMS_SEQ_SAFETY) | (nxt_seq == GMS_SEQ_RUN);
  assign nxt_starter = (nxt_seq == GMS_SEQ_CRANK);
  // ECU priming stays on in stop mode once start is pressed.
  assign nxt_prime   = (in_stop & !enter_stop & nxt_mode == GMS_MODE_STOP)
                     & (press.start | prime_ff);
  // Generator switch opens first; fuel stays off only afterwards.
  assign nxt_gen_sw  = want_gen_load & !(mode_req & press.stop_reset)
                     & ((in_manual & (load_req | gen_sw_ff)
                         & !press.open_gen)
                        | (!in_manual & gen_sw_ff));
  assign nxt_mains_sw = (in_stop & cfg.mains_dropout) ? mains_s
                      : mains_sw_ff;
  assign nxt_idle  = (any_press | commq_s | !in_stop) ? TMR_ZERO
                   : idle_done ? idle_ff : idle_ff + TMR_ONE;
  assign nxt_psave = cfg.power_save_en & in_stop & idle_done
                   & !any_press;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      fuel_ff     <= 1'b0;
      starter_ff  <= 1'b0;
      can_ff      <= 1'b0;
      prime_ff    <= 1'b0;
      gen_sw_ff   <= 1'b0;
      mains_sw_ff <= 1'b0;
      mask_ff     <= 1'b0;
      psave_ff    <= 1'b0;
      idle_ff     <= TMR_ZERO;
      cfg_ok_ff   <= 1'b0;
      rest_ff     <= 1'b0;
      fst_late_ff <= 1'b0;
    end
    else
    begin
      // Fuel is cut only once the generator switch is already open.
      fuel_ff     <= nxt_fuel | (fuel_ff & gen_sw_ff);
      starter_ff  <= nxt_starter;
      can_ff      <= cfg.can_engine & nxt_starter;
      prime_ff    <= nxt_prime;
      gen_sw_ff   <= nxt_gen_sw;
      mains_sw_ff <= nxt_mains_sw;
      mask_ff     <= (nxt_seq == GMS_SEQ_SAFETY);
      psave_ff    <= nxt_psave;
      idle_ff     <= nxt_idle;
      cfg_ok_ff   <= in_stop & at_rest;
      rest_ff     <= at_rest;
      fst_late_ff <= fst_ff;
    end
  end

  assign mode                  = mode_ff;
  assign fuel_relay            = fuel_ff;
  assign starter               = starter_ff;
  assign can_start_cmd         = can_ff;
  assign engine_computer_prime = prime_ff;
  assign gen_load_switch       = gen_sw_ff;
  assign mains_load_switch     = mains_sw_ff;
  assign safety_mask           = mask_ff;
  assign stop_timeout_alarm    = fts_ff;
  assign start_exhausted_alarm = fst_late_ff;
  assign latched_alarm_reset   = alm_rst_ff;
  assign power_save            = psave_ff;
  assign config_allowed        = cfg_ok_ff;
  assign engine_at_rest        = rest_ff;

endmodule : gms_sequencer

// >>> gms_sequencer_chk.sv
// Concurrent assertions on the ports of the genset mode sequencer.
`timescale 1ns/100ps
module gms_sequencer_chk
(
  input wire logic                     clk,
  input wire logic                     rst_n,
  input wire gms_pkg::gms_buttons_type buttons,
  input wire logic                     panel_lock,
  input wire logic                     comms_active,
  input wire gms_pkg::gms_rest_type    rest_in,
  input wire gms_pkg::gms_fire_type    fire_in,
  input wire logic                     gen_available,
  input wire logic                     mains_ok,
  input wire logic                     aux_load_req,
  input wire logic                     remote_load_req,
  input wire logic                     load_inhibit,
  input wire logic                     alarm_cond_clear,
  input wire gms_pkg::gms_cfg_type     cfg,
  input wire gms_pkg::gms_mode_type    mode,
  input wire logic                     fuel_relay,
  input wire logic                     starter,
  input wire logic                     can_start_cmd,
  input wire logic                     engine_computer_prime,
  input wire logic                     gen_load_switch,
  input wire logic                     mains_load_switch,
  input wire logic                     safety_mask,
  input wire logic                     stop_timeout_alarm,
  input wire logic                     start_exhausted_alarm,
  input wire logic                     latched_alarm_reset,
  input wire logic                     power_save,
  input wire logic                     config_allowed,
  input wire logic                     engine_at_rest
);
  import gms_pkg::*;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_crank_fuel: assert property (starter |-> fuel_relay)
    else $error("starter engaged without fuel");
  a_stop_no_crank: assert property (mode == GMS_MODE_STOP &&
    $past(mode) == GMS_MODE_STOP |-> !starter)
    else $error("starter engaged in stop mode");
  a_prime_stop: assert property (engine_computer_prime |->
    mode == GMS_MODE_STOP || $past(mode) == GMS_MODE_STOP)
    else $error("prime outside stop mode");
  a_open_first: assert property ($fell(fuel_relay) |->
    !$past(gen_load_switch))
    else $error("fuel dropped before load switch opened");
  a_mask_release: assert property ($rose(safety_mask) |->
    $fell(starter) && fuel_relay)
    else $error("safety mask not tied to starter release");
  a_exhaust_off: assert property ($rose(start_exhausted_alarm) |->
    !starter && !fuel_relay)
    else $error("start alarm with engine still driven");
  a_load_gate: assert property ($rose(gen_load_switch) |->
    mode == GMS_MODE_MANUAL && fuel_relay)
    else $error("load switch closed without running set");
  a_reset_pulse: assert property (latched_alarm_reset |=>
    !latched_alarm_reset)
    else $error("alarm reset longer than one cycle");
  a_stop_alarm: assert property ($rose(stop_timeout_alarm) |->
    mode == GMS_MODE_STOP && !engine_at_rest)
    else $error("stop alarm without running engine");
  a_lock_mode: assert property (&{$past(panel_lock, 4),
    $past(panel_lock, 5), $past(panel_lock, 6), $past(panel_lock, 7)}
    |-> $stable(mode))
    else $error("mode changed under panel lock");
  a_save_stop: assert property (power_save |-> mode == GMS_MODE_STOP)
    else $error("power save outside stop mode");
  a_rest_all: assert property ($rose(engine_at_rest) |->
    $past(&rest_in, 5) || $past(&rest_in, 6))
    else $error("at rest without all rest conditions");
endmodule : gms_sequencer_chk

bind gms_sequencer gms_sequencer_chk i_gms_sequencer_chk (.*);

// >>> gms_engine_model.sv
// Behavioural engine with fuel relay, starter and rest sensors.
`timescale 1ns/100ps
module gms_engine_model
(
  input  wire logic             clk,
  input  wire logic             fuel_relay,
  input  wire logic             starter,
  input  wire logic [3:0]       fire_try,
  input  wire logic             hold_spin,
  output gms_pkg::gms_rest_type rest_in,
  output gms_pkg::gms_fire_type fire_in
);
  import gms_pkg::*;

  // The engine fires on crank attempt fire_try; zero never fires.
  logic [3:0] tries_ff;
  logic [2:0] crank_ff;
  logic       fired_ff;
  logic       start_d_ff;

  assign rest_in = {5{~(hold_spin | fired_ff)}};
  assign fire_in = {fired_ff, 3'h0};

  always_ff @(posedge clk)
  begin
    start_d_ff <= starter;
    crank_ff <= starter ? crank_ff + 3'h1 : 3'h0;
    if (!fuel_relay)
    begin
      tries_ff <= 4'h0;
      fired_ff <= 1'b0;
    end
    else
    begin
      if (starter && !start_d_ff)
        tries_ff <= tries_ff + 4'h1;
      if (starter && crank_ff == 3'h4 && tries_ff == fire_try)
        fired_ff <= (fire_try != 4'h0);
    end
  end
endmodule : gms_engine_model

// >>> gms_testbench.sv
// Self-checking testbench for the genset mode sequencer.
`timescale 1ns/100ps
module testbench;
  import gms_pkg::*;

  localparam gms_buttons_type BTN_STOP = 7'h40;
  localparam gms_buttons_type BTN_MAN  = 7'h20;
  localparam gms_buttons_type BTN_GO   = 7'h04;
  localparam gms_buttons_type BTN_GEN  = 7'h02;
  logic            clk = 1'b0;
  logic            rst_n = 1'b0;
  gms_buttons_type buttons = '0;
  logic            panel_lock = 1'b0;
  logic            comms_active = 1'b1;
  logic            gen_available = 1'b0;
  logic            mains_ok = 1'b0;
  logic            aux_load_req = 1'b0;
  logic            remote_load_req = 1'b0;
  logic            load_inhibit = 1'b0;
  logic            alarm_cond_clear = 1'b0;
  logic            hold_spin = 1'b0;
  logic [3:0]      fire_try = 4'h0;
  gms_cfg_type     cfg;
  gms_rest_type    rest_in;
  gms_fire_type    fire_in;
  gms_mode_type    mode;
  logic fuel_relay, starter, can_start_cmd, engine_computer_prime, st_d;
  logic gen_load_switch, mains_load_switch, safety_mask, power_save;
  logic stop_timeout_alarm, start_exhausted_alarm, latched_alarm_reset;
  logic config_allowed, engine_at_rest;
  int   fail_count = 0, samples_checked = 0, crank_starts = 0, pulses = 0;

  gms_sequencer #(.IDLE_LIMIT(64)) i_gms_sequencer (.*);
  gms_engine_model i_gms_engine_model (.*);

  always #2 clk = ~clk;

  always @(posedge clk)
  begin
    if (starter === 1'b1 && st_d !== 1'b1)
      crank_starts++;
    st_d <= starter;
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n)
    begin
      @(negedge clk);
      if (latched_alarm_reset === 1'b1)
        pulses++;
    end
  endtask : cyc

  task automatic press(input gms_buttons_type b);
    @(posedge clk);
    buttons <= b;
    cyc(8);
    @(posedge clk);
    buttons <= '0;
    cyc(8);
  endtask : press

  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_stop_mode;
    cyc(100);
    check(power_save === 1'b0, "sleep with comms");
    @(posedge clk);
    comms_active <= 1'b0;
    cyc(100);
    check(power_save === 1'b1, "no power save");
    press(BTN_GO);
    check(engine_computer_prime === 1'b1 && starter === 1'b0, "prime");
    check(fuel_relay === 1'b0 && power_save === 1'b0, "wake");
    @(posedge clk);
    mains_ok <= 1'b1;
    cyc(10);
    check(mains_load_switch === 1'b1, "mains close");
    @(posedge clk);
    mains_ok <= 1'b0;
    panel_lock <= 1'b1;
    cyc(10);
    check(mains_load_switch === 1'b0, "mains open");
    press(BTN_MAN);
    check(mode === GMS_MODE_STOP, "locked mode change");
    @(posedge clk);
    panel_lock <= 1'b0;
    cyc(10);
    press(BTN_MAN);
    check(mode === GMS_MODE_MANUAL && starter === 1'b0, "manual");
    $display("t_stop_mode done");
  endtask : t_stop_mode

  task automatic t_start_fail;
    crank_starts = 0;
    press(BTN_GO);
    check(starter === 1'b1 && fuel_relay === 1'b1, "crank");
    check(can_start_cmd === 1'b1, "can start");
    for (int i = 0; i < 600 && start_exhausted_alarm !== 1'b1; i++)
      cyc(1);
    check(crank_starts == cfg.crank_try_limit, "attempts");
    check(start_exhausted_alarm === 1'b1, "no start alarm");
    $display("t_start_fail done");
  endtask : t_start_fail

  task automatic t_run;
    int n;
    @(posedge clk);
    fire_try <= 4'h2;
    crank_starts = 0;
    press(BTN_GO);
    for (int i = 0; i < 300 && safety_mask !== 1'b1; i++)
      cyc(1);
    check(crank_starts == 2 && starter === 1'b0, "fire cut-out");
    check(start_exhausted_alarm === 1'b0, "stale alarm");
    n = 0;
    while (safety_mask === 1'b1 && n < 200)
    begin
      n++;
      cyc(1);
    end
    check(n == cfg.safety_ticks + 1, "safety length");
    press(BTN_GEN);
    check(gen_load_switch === 1'b0, "load not available");
    @(posedge clk);
    gen_available <= 1'b1;
    cyc(10);
    press(BTN_GEN);
    check(gen_load_switch === 1'b1, "load");
    @(posedge clk);
    load_inhibit <= 1'b1;
    cyc(10);
    check(gen_load_switch === 1'b0, "inhibit");
    @(posedge clk);
    load_inhibit <= 1'b0;
    press(BTN_GEN);
    check(gen_load_switch === 1'b1, "reload");
    press(BTN_STOP);
    check(mode === GMS_MODE_STOP && gen_load_switch === 1'b0, "stop");
    cyc(60);
    check(engine_at_rest === 1'b1 && stop_timeout_alarm === 1'b0, "rest");
    check(config_allowed === 1'b1, "config");
    $display("t_run done");
  endtask : t_run

  task automatic t_stop_fail;
    press(BTN_MAN);
    @(posedge clk);
    hold_spin <= 1'b1;
    press(BTN_STOP);
    cyc(60);
    check(stop_timeout_alarm === 1'b1, "no stop alarm");
    check(engine_at_rest === 1'b0 && config_allowed === 1'b0, "spin");
    @(posedge clk);
    hold_spin <= 1'b0;
    alarm_cond_clear <= 1'b1;
    press(BTN_MAN);
    pulses = 0;
    press(BTN_STOP);
    check(pulses == 1 && stop_timeout_alarm === 1'b0, "alarm reset");
    $display("t_stop_fail done");
  endtask : t_stop_fail

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    print_verdict();
  end

  initial
  begin
    cfg = '0;
    cfg.can_engine = 1'b1;
    cfg.manual_breaker = 1'b1;
    cfg.mains_dropout = 1'b1;
    cfg.power_save_en = 1'b1;
    cfg.crank_try_limit = 4'h3;
    cfg.crank_ticks = 32'h0000_0014;
    cfg.rest_ticks = 32'h0000_000A;
    cfg.safety_ticks = 32'h0000_000F;
    cfg.stop_ticks = 32'h0000_001E;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    cyc(10);
    t_stop_mode();
    t_start_fail();
    t_run();
    t_stop_fail();
    print_verdict();
  end
endmodule : testbench
